// ---- logic/csi_pkg.sv ----
// Purpose: shared constants and types for the core status, interrupt and configuration registers
// Assumes: one core clock, registers reached over the core register port and the host port
// Notes: field positions of the configuration word are carried by csi_cfg_s
package csi_pkg;

    // ==================================================================
    // register selection and addresses
    typedef enum logic [1:0] {
        CSI_SEL_CONFIG,
        CSI_SEL_STICKY,
        CSI_SEL_LATCH,
        CSI_SEL_MASK
    } csi_sel_e;

    localparam logic [7:0] CSI_CONFIG_ADDR = 8'h00;

    // ==================================================================
    // sticky status bit positions
    localparam int CSI_ALU_UNF = 0;
    localparam int CSI_ALU_OVF = 1;
    localparam int CSI_ALU_FIX = 2;
    localparam int CSI_ALU_INV = 5;
    localparam int CSI_MUL_FIX = 6;
    localparam int CSI_MUL_OVF = 7;
    localparam int CSI_MUL_UNF = 8;
    localparam int CSI_MUL_INV = 9;
    localparam int CSI_CB7 = 17;
    localparam int CSI_CB15 = 18;
    localparam int CSI_PC_FULL = 21;
    localparam int CSI_PC_EMPTY = 22;
    localparam int CSI_SS_OVF = 23;
    localparam int CSI_SS_EMPTY = 24;
    localparam int CSI_LS_OVF = 25;
    localparam int CSI_LS_EMPTY = 26;
    localparam logic [31:0] CSI_STICKY_STATUS_SW_MASK = 32'h0006_03e7;
    localparam logic [31:0] CSI_STICKY_STATUS_RESET = 32'h0000_0000;

    // ==================================================================
    // interrupt latch and mask
    localparam int CSI_IRQ_RESET = 1;
    localparam int CSI_IRQ_STACK = 3;
    localparam int CSI_IRQ_TMR_HI = 4;
    localparam int CSI_IRQ_VECTOR = 5;
    localparam int CSI_IRQ_EXT = 6;
    localparam int CSI_IRQ_DMA = 10;
    localparam int CSI_IRQ_LINK = 20;
    localparam int CSI_IRQ_CB = 21;
    localparam int CSI_IRQ_TMR_LO = 23;
    localparam int CSI_IRQ_ARITH = 24;
    localparam logic [31:0] CSI_LATCH_WR_MASK = 32'hffff_fdf8;
    localparam logic [31:0] CSI_MASK_FORCED = 32'h0000_0002;
    // mask reset value is arbitrary: only the reset interrupt enabled
    localparam logic [31:0] CSI_MASK_RESET = 32'h0000_0002;
    localparam logic [31:0] CSI_VEC_INT_BASE = 32'h0002_0000;
    localparam logic [31:0] CSI_VEC_EXT_BASE = 32'h0040_0000;
    localparam int CSI_VEC_SHIFT = 2;

    // ==================================================================
    // configuration word
    localparam logic [31:0] CSI_CFG_RESET = 32'h0000_0010;
    localparam logic [31:0] CSI_CFG_DEFINED = 32'h1007_ff7f;
    localparam logic [1:0] CSI_HPM_NONE = 2'h0;
    localparam logic [1:0] CSI_HPM_16_32 = 2'h1;
    localparam logic [1:0] CSI_HPM_16_48 = 2'h2;
    localparam logic [1:0] CSI_HPM_32_48 = 2'h3;

    typedef struct packed {
        logic [2:0] rsv_hi;
        logic memory_grouping;
        logic [8:0] rsv_mid;
        logic dma_priority_sel;
        logic [1:0] ext_bus_priority;
        logic [3:0] bank_size_field;
        logic buffer_hang_disable;
        logic ready_drive_sel;
        logic block1_width;
        logic block0_width;
        logic host_pack_flush;
        logic host_pack_order;
        logic [1:0] host_packing_field;
        logic instruction_word_transfer;
        logic internal_vector_table_sel;
        logic boot_select_override;
        logic soft_reset_bit;
    } csi_cfg_s;

    typedef enum logic {
        CSI_PACK_FIRST,
        CSI_PACK_SECOND
    } csi_pack_e;

    // ==================================================================
    // event and control carriers
    typedef struct packed {
        logic alu_unf;
        logic alu_ovf;
        logic alu_fix;
        logic alu_inv;
        logic mul_fix;
        logic mul_ovf;
        logic mul_unf;
        logic mul_inv;
        logic cb7_ovf;
        logic cb15_ovf;
    } csi_arith_s;

    typedef struct packed {
        logic pc_full;
        logic pc_empty;
        logic ss_ovf;
        logic ss_empty;
        logic ls_ovf;
        logic ls_empty;
    } csi_stack_s;

    typedef struct packed {
        logic tmr_zero;
        logic vector_irq;
        logic [2:0] ext_irq;
        logic [9:0] dma_done;
        logic link_req;
        logic [3:0] arith_exc;
    } csi_irqsrc_s;

    typedef struct packed {
        logic mem_select_en;
        logic boot_mem_sel;
        logic direct_word48;
        logic ready_out;
        logic ready_oe_n;
    } csi_ctrl_s;

endpackage

// ---- logic/csi_regs.sv ----
// Purpose: sticky status, interrupt latch and mask, and system configuration registers
// Assumes: inputs synchronous to clk_sys, hardware events are one-cycle or level sets
// Notes: core port reaches all four registers, host port reaches the configuration word only
//
// Contract
// - stack status bits 21 to 26 ignore software writes.
// - defined status bits stay set until cleared, except 21, 22, 24, 26 which are live.
// - arithmetic sticky bits: 0 underflow, 1 overflow, 2 fixed overflow, 5 invalid.
// - multiplier sticky bits: 6 fixed overflow, 7 overflow, 8 underflow, 9 invalid.
// - bit 17 records buffer 7 overflow, bit 18 buffer 15 overflow.
// - stack flags at 21 to 26: pc full/empty, status, loop overflow/empty.
// - latch and mask share bit positions; lower bit index wins priority.
// - interrupt vector sits at four times its bit index from table base.
// - reset clears latch; mask one enables; reset interrupt read-only, never masked.
// - sources: stack 3, timer 4 and 23, buffers 21-22, arithmetic 24-27, software 28-31.
// - dma channels 0-9 at bits 10-19, pins at 6-8, link requests at 20.
// - configuration word answers at address zero and resets to 16-bit packing.
// - packing field bits 4-5: none, 16-32, 16-48, 32-48.
// - configuration bit 0 performs a reset equal to the reset pin.
// - bit 1 disables memory selects and drives the boot memory select.
// - bit 2 picks internal or external vector table in no-boot mode only.
// - bit 3 forces 48-bit direct transfers over block width bits.
// - bits 8 and 9 choose 32 or 40 bit data for blocks 0 and 1.
// - bit 6 selects packing order, bit 7 flushes packing state.
// - bits 16-17 bus priority, bit 18 rotating or sequential dma priority.
// - bit 10 ready drive, bit 11 hang prevention, bits 12-15 bank size.
`timescale 1ns/1ns

module csi_regs (
    // clock and reset
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic ce,
    // core register port
    input wire logic core_wr,
    input wire logic core_rd,
    input wire csi_pkg::csi_sel_e core_sel,
    input wire logic [31:0] core_wdata,
    output logic [31:0] core_rdata_reg,
    // host port to the configuration word
    input wire logic host_wr,
    input wire logic host_rd,
    input wire logic [7:0] host_addr,
    input wire logic [31:0] host_wdata,
    output logic [31:0] host_rdata_reg,
    // hardware events and levels
    input wire csi_pkg::csi_arith_s arith_i,
    input wire csi_pkg::csi_stack_s stack_i,
    input wire csi_pkg::csi_irqsrc_s irqsrc_i,
    input wire logic boot_mode_i,
    input wire logic dev_ready_i,
    // results
    output csi_pkg::csi_cfg_s cfg_reg,
    output csi_pkg::csi_ctrl_s ctrl_reg,
    output logic irq_req_reg,
    output logic [31:0] irq_vector_reg,
    output logic soft_reset_reg
);

    // ==================================================================
    // helpers
    function automatic logic [4:0] first_idx(input logic [31:0] pend);
        logic [4:0] idx;
        idx = 5'h00;
        for (int i = 31; i >= 0; i--) begin
            if (pend[i]) begin
                idx = 5'(i);
            end
        end
        return idx;
    endfunction

    logic [31:0] sticky_reg, sticky_next, latch_reg, latch_next, mask_reg, mask_next;
    logic [31:0] evt_vec, live_vec, src_vec, pend_next, pend_cur, vec_base;
    logic [31:0] cfg_word, core_rdata_next, host_rdata_next, irq_vector_next;
    logic [15:0] hold_reg, hold_next;
    csi_pkg::csi_pack_e pack_reg, pack_next;
    csi_pkg::csi_cfg_s cfg_next, cfg_in;
    csi_pkg::csi_ctrl_s ctrl_next;
    logic cfg_wr, host_cfg, host_commit, irq_req_next, soft_reset_bit_next;

    // ==================================================================
    // event mapping
    always_comb begin
        evt_vec = '0;
        evt_vec[csi_pkg::CSI_ALU_UNF] = arith_i.alu_unf;
        evt_vec[csi_pkg::CSI_ALU_OVF] = arith_i.alu_ovf;
        evt_vec[csi_pkg::CSI_ALU_FIX] = arith_i.alu_fix;
        evt_vec[csi_pkg::CSI_ALU_INV] = arith_i.alu_inv;
        evt_vec[csi_pkg::CSI_MUL_FIX] = arith_i.mul_fix;
        evt_vec[csi_pkg::CSI_MUL_OVF] = arith_i.mul_ovf;
        evt_vec[csi_pkg::CSI_MUL_UNF] = arith_i.mul_unf;
        evt_vec[csi_pkg::CSI_MUL_INV] = arith_i.mul_inv;
        evt_vec[csi_pkg::CSI_CB7] = arith_i.cb7_ovf;
        evt_vec[csi_pkg::CSI_CB15] = arith_i.cb15_ovf;
        evt_vec[csi_pkg::CSI_SS_OVF] = stack_i.ss_ovf;
        evt_vec[csi_pkg::CSI_LS_OVF] = stack_i.ls_ovf;
        live_vec = '0;
        live_vec[csi_pkg::CSI_PC_FULL] = stack_i.pc_full;
        live_vec[csi_pkg::CSI_PC_EMPTY] = stack_i.pc_empty;
        live_vec[csi_pkg::CSI_SS_EMPTY] = stack_i.ss_empty;
        live_vec[csi_pkg::CSI_LS_EMPTY] = stack_i.ls_empty;
        src_vec = '0;
        src_vec[csi_pkg::CSI_IRQ_STACK] = stack_i.ss_ovf | stack_i.ls_ovf | stack_i.pc_full;
        src_vec[csi_pkg::CSI_IRQ_TMR_HI] = irqsrc_i.tmr_zero;
        src_vec[csi_pkg::CSI_IRQ_TMR_LO] = irqsrc_i.tmr_zero;
        src_vec[csi_pkg::CSI_IRQ_VECTOR] = irqsrc_i.vector_irq;
        src_vec[csi_pkg::CSI_IRQ_EXT +: 3] = irqsrc_i.ext_irq;
        src_vec[csi_pkg::CSI_IRQ_DMA +: 10] = irqsrc_i.dma_done;
        src_vec[csi_pkg::CSI_IRQ_LINK] = irqsrc_i.link_req;
        src_vec[csi_pkg::CSI_IRQ_CB] = arith_i.cb7_ovf;
        src_vec[csi_pkg::CSI_IRQ_CB + 1] = arith_i.cb15_ovf;
        src_vec[csi_pkg::CSI_IRQ_ARITH +: 4] = irqsrc_i.arith_exc;
    end

    // ==================================================================
    // status, latch and mask
    always_comb begin
        sticky_next = sticky_reg;
        latch_next = latch_reg;
        mask_next = mask_reg;
        if (core_wr && core_sel == csi_pkg::CSI_SEL_STICKY) begin
            // stack bits are outside the software mask
            sticky_next = (sticky_reg & ~csi_pkg::CSI_STICKY_STATUS_SW_MASK)
                | (core_wdata & csi_pkg::CSI_STICKY_STATUS_SW_MASK);
        end
        sticky_next = sticky_next | evt_vec;
        sticky_next[csi_pkg::CSI_PC_FULL] = live_vec[csi_pkg::CSI_PC_FULL];
        sticky_next[csi_pkg::CSI_PC_EMPTY] = live_vec[csi_pkg::CSI_PC_EMPTY];
        sticky_next[csi_pkg::CSI_SS_EMPTY] = live_vec[csi_pkg::CSI_SS_EMPTY];
        sticky_next[csi_pkg::CSI_LS_EMPTY] = live_vec[csi_pkg::CSI_LS_EMPTY];
        if (core_wr && core_sel == csi_pkg::CSI_SEL_LATCH) begin
            // software interrupts 28-31 are raised by writing ones here
            latch_next = core_wdata & csi_pkg::CSI_LATCH_WR_MASK;
        end
        latch_next = latch_next | src_vec;
        if (core_wr && core_sel == csi_pkg::CSI_SEL_MASK) begin
            mask_next = (core_wdata & csi_pkg::CSI_LATCH_WR_MASK)
                | csi_pkg::CSI_MASK_FORCED;
        end
        if (soft_reset_reg) begin
            sticky_next = csi_pkg::CSI_STICKY_STATUS_RESET;
            latch_next = '0;
            mask_next = csi_pkg::CSI_MASK_RESET;
        end
    end

    // ==================================================================
    // configuration word and host packing
    always_comb begin
        cfg_word = 32'(cfg_reg);
        cfg_next = cfg_reg;
        hold_next = hold_reg;
        pack_next = pack_reg;
        host_cfg = host_wr && host_addr == csi_pkg::CSI_CONFIG_ADDR;
        host_commit = 1'b0;
        soft_reset_bit_next = 1'b0;
        if (host_cfg) begin
            // 16-bit host modes assemble two halves before committing
            case (cfg_reg.host_packing_field)
                csi_pkg::CSI_HPM_16_32, csi_pkg::CSI_HPM_16_48: begin
                    case (pack_reg)
                        csi_pkg::CSI_PACK_FIRST: begin
                            hold_next = host_wdata[15:0];
                            pack_next = csi_pkg::CSI_PACK_SECOND;
                        end
                        csi_pkg::CSI_PACK_SECOND: begin
                            cfg_word = cfg_reg.host_pack_order
                                ? {hold_reg, host_wdata[15:0]}
                                : {host_wdata[15:0], hold_reg};
                            host_commit = 1'b1;
                            pack_next = csi_pkg::CSI_PACK_FIRST;
                        end
                        default: pack_next = csi_pkg::CSI_PACK_FIRST;
                    endcase
                end
                default: begin
                    cfg_word = host_wdata;
                    host_commit = 1'b1;
                end
            endcase
        end
        // core write wins over a host write in the same cycle
        if (core_wr && core_sel == csi_pkg::CSI_SEL_CONFIG) begin
            cfg_word = core_wdata;
        end
        cfg_in = csi_pkg::csi_cfg_s'(cfg_word);
        cfg_wr = (core_wr && core_sel == csi_pkg::CSI_SEL_CONFIG) || host_commit;
        if (cfg_wr) begin
            cfg_next = csi_pkg::csi_cfg_s'(cfg_word & csi_pkg::CSI_CFG_DEFINED);
            soft_reset_bit_next = cfg_in.soft_reset_bit;
            cfg_next.soft_reset_bit = 1'b0;
            if (cfg_in.host_pack_flush) begin
                pack_next = csi_pkg::CSI_PACK_FIRST;
            end
        end
        if (soft_reset_reg) begin
            cfg_next = csi_pkg::csi_cfg_s'(csi_pkg::CSI_CFG_RESET);
            pack_next = csi_pkg::CSI_PACK_FIRST;
            hold_next = '0;
            soft_reset_bit_next = 1'b0;
        end
    end

    // ==================================================================
    // derived controls, interrupt request and read data
    always_comb begin
        ctrl_next.mem_select_en = !cfg_next.boot_select_override;
        ctrl_next.boot_mem_sel = cfg_next.boot_select_override;
        // block width bits still steer 40-bit data when this is low
        ctrl_next.direct_word48 = cfg_next.instruction_word_transfer;
        ctrl_next.ready_out = dev_ready_i;
        // open drain drives only the low level
        ctrl_next.ready_oe_n = !(cfg_next.ready_drive_sel || !dev_ready_i);
        vec_base = (boot_mode_i || cfg_next.internal_vector_table_sel)
            ? csi_pkg::CSI_VEC_INT_BASE : csi_pkg::CSI_VEC_EXT_BASE;
        pend_next = latch_next & mask_next;
        irq_req_next = |pend_next;
        irq_vector_next = vec_base
            + (32'(first_idx(pend_next)) << csi_pkg::CSI_VEC_SHIFT);
        core_rdata_next = core_rdata_reg;
        if (core_rd) begin
            case (core_sel)
                csi_pkg::CSI_SEL_CONFIG: core_rdata_next = 32'(cfg_reg);
                csi_pkg::CSI_SEL_STICKY: core_rdata_next = sticky_reg;
                csi_pkg::CSI_SEL_LATCH: core_rdata_next = latch_reg;
                csi_pkg::CSI_SEL_MASK: core_rdata_next = mask_reg;
                default: core_rdata_next = '0;
            endcase
        end
        host_rdata_next = host_rdata_reg;
        if (host_rd) begin
            host_rdata_next = (host_addr == csi_pkg::CSI_CONFIG_ADDR) ? 32'(cfg_reg) : '0;
        end
        if (soft_reset_reg) begin
            core_rdata_next = '0;
            host_rdata_next = '0;
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            sticky_reg <= csi_pkg::CSI_STICKY_STATUS_RESET;
            latch_reg <= '0;
            mask_reg <= csi_pkg::CSI_MASK_RESET;
            cfg_reg <= csi_pkg::csi_cfg_s'(csi_pkg::CSI_CFG_RESET);
            hold_reg <= '0;
            pack_reg <= csi_pkg::CSI_PACK_FIRST;
            ctrl_reg <= '{mem_select_en: 1'b1, ready_oe_n: 1'b1, default: 1'b0};
            irq_req_reg <= 1'b0;
            irq_vector_reg <= csi_pkg::CSI_VEC_EXT_BASE;
            core_rdata_reg <= '0;
            host_rdata_reg <= '0;
            soft_reset_reg <= 1'b0;
        end else if (ce) begin
            sticky_reg <= sticky_next;
            latch_reg <= latch_next;
            mask_reg <= mask_next;
            cfg_reg <= cfg_next;
            hold_reg <= hold_next;
            pack_reg <= pack_next;
            ctrl_reg <= ctrl_next;
            irq_req_reg <= irq_req_next;
            irq_vector_reg <= irq_vector_next;
            core_rdata_reg <= core_rdata_next;
            host_rdata_reg <= host_rdata_next;
            soft_reset_reg <= soft_reset_bit_next;
        end
    end

    // ==================================================================
    // checks
    assign pend_cur = latch_reg & mask_reg;

    stack_readonly_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (ce && !soft_reset_reg && sticky_reg[csi_pkg::CSI_SS_OVF]) |=> sticky_reg[csi_pkg::CSI_SS_OVF])
        else $error("status stack overflow bit lost");
    sticky_hold_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (ce && !soft_reset_reg && sticky_reg[csi_pkg::CSI_MUL_INV]
            && !(core_wr && core_sel == csi_pkg::CSI_SEL_STICKY))
        |=> sticky_reg[csi_pkg::CSI_MUL_INV])
        else $error("sticky bit dropped without a clear");
    live_follow_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (ce && !soft_reset_reg) |=> sticky_reg[csi_pkg::CSI_PC_EMPTY] == $past(stack_i.pc_empty))
        else $error("pc stack empty does not follow its level");
    set_wins_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (ce && !soft_reset_reg && arith_i.alu_unf) |=> sticky_reg[csi_pkg::CSI_ALU_UNF])
        else $error("underflow event lost");
    latch_clear_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (ce && soft_reset_reg) |=> (latch_reg == '0 && mask_reg[csi_pkg::CSI_IRQ_RESET]))
        else $error("soft reset left latch set");
    dma_map_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (ce && !soft_reset_reg && irqsrc_i.dma_done[9]) |=> latch_reg[19])
        else $error("dma channel 9 not latched at bit 19");
    vector_prio_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        pend_cur[csi_pkg::CSI_IRQ_TMR_HI]
        |-> (irq_req_reg && irq_vector_reg[6:0] <= 7'h10))
        else $error("timer vector outranked by lower priority");
    cfg_reset_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (ce && soft_reset_reg) |=> (32'(cfg_reg) == csi_pkg::CSI_CFG_RESET && !soft_reset_reg))
        else $error("configuration not reloaded");
    soft_reset_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (ce && !soft_reset_reg && core_wr && core_sel == csi_pkg::CSI_SEL_CONFIG && core_wdata[0])
        |=> soft_reset_reg ##1 (!ce || latch_reg == '0))
        else $error("software reset not raised");
    boot_sel_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        ctrl_reg.boot_mem_sel |-> (!ctrl_reg.mem_select_en && cfg_reg.boot_select_override))
        else $error("memory selects active with boot override");
    flush_zero_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        !cfg_reg.host_pack_flush)
        else $error("flush bit reads as one");

    pack_cover_c: cover property (@(posedge clk_sys) disable iff (!reset_n)
        ce && host_commit && pack_reg == csi_pkg::CSI_PACK_SECOND);
    irq_cover_c: cover property (@(posedge clk_sys) disable iff (!reset_n)
        ce && irq_req_reg && pend_cur[csi_pkg::CSI_IRQ_DMA]);
    clear_cover_c: cover property (@(posedge clk_sys) disable iff (!reset_n)
        ce && core_wr && core_sel == csi_pkg::CSI_SEL_STICKY && arith_i.alu_unf);

endmodule

// ---- tb/csi_regs_test.sv ----
// Purpose: self-checking bench for the status, interrupt and configuration registers
// Assumes: ce held high; dev_ready_i and boot_mode_i rest high and low (no-boot mode)
// Notes: inputs change 10 ns after each rising edge; every task but cmp, end_sim and t_reset starts on a fresh edge
`timescale 1ns/1ns
module csi_regs_test;
    logic clk_sys = 1'b0;
    logic reset_n = 1'b0;
    logic core_wr = 1'b0, core_rd = 1'b0, host_wr = 1'b0, host_rd = 1'b0;
    csi_pkg::csi_sel_e core_sel = csi_pkg::CSI_SEL_CONFIG;
    logic [31:0] core_wdata = 32'h0, host_wdata = 32'h0, core_rdata_reg, host_rdata_reg;
    logic [31:0] irq_vector_reg, rd;
    logic [7:0] host_addr = 8'h00;
    csi_pkg::csi_arith_s arith_i = '0;
    csi_pkg::csi_stack_s stack_i = '0;
    csi_pkg::csi_irqsrc_s irqsrc_i = '0;
    csi_pkg::csi_cfg_s cfg_reg;
    csi_pkg::csi_ctrl_s ctrl_reg;
    logic irq_req_reg, soft_reset_reg;
    logic boot_mode_i = 1'b0, dev_ready_i = 1'b1;
    int n_mismatch = 0;
    int n_checks = 0;
    csi_regs i_dut (.clk_sys(clk_sys), .reset_n(reset_n), .ce(1'b1), .core_wr(core_wr),
        .core_rd(core_rd), .core_sel(core_sel), .core_wdata(core_wdata),
        .core_rdata_reg(core_rdata_reg), .host_wr(host_wr), .host_rd(host_rd),
        .host_addr(host_addr), .host_wdata(host_wdata), .host_rdata_reg(host_rdata_reg),
        .arith_i(arith_i), .stack_i(stack_i), .irqsrc_i(irqsrc_i), .boot_mode_i(boot_mode_i),
        .dev_ready_i(dev_ready_i), .cfg_reg(cfg_reg), .ctrl_reg(ctrl_reg),
        .irq_req_reg(irq_req_reg), .irq_vector_reg(irq_vector_reg),
        .soft_reset_reg(soft_reset_reg));
    always #50 clk_sys = ~clk_sys;
    // ==============================================================
    // shared tasks
    task cyc;
        @(posedge clk_sys);
        #10;
    endtask
    task cmp(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task cwr(input csi_pkg::csi_sel_e s, input logic [31:0] d);
        cyc;
        core_sel = s;
        core_wdata = d;
        core_wr = 1'b1;
        cyc;
        core_wr = 1'b0;
    endtask
    // read data stands until the next read or a soft reset, so one spare edge is harmless
    task crd(input csi_pkg::csi_sel_e s, input logic [31:0] exp);
        cyc;
        core_sel = s;
        core_rd = 1'b1;
        cyc;
        core_rd = 1'b0;
        cyc;
        cmp(core_rdata_reg, exp);
    endtask
    task end_sim;
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    // ==============================================================
    // scenarios
    task t_reset;
        cmp(cfg_reg, 32'h0000_0010);
        cmp({30'h0, ctrl_reg.mem_select_en, ctrl_reg.ready_oe_n}, 32'h3);
        cmp(irq_vector_reg, 32'h0040_0000);
        boot_mode_i = 1'b1;
        dev_ready_i = 1'b0;
        cyc;
        boot_mode_i = 1'b0;
        dev_ready_i = 1'b1;
        cmp(irq_vector_reg, 32'h0002_0000);
        cmp({30'h0, ctrl_reg.ready_out, ctrl_reg.ready_oe_n}, 32'h0);
        crd(csi_pkg::CSI_SEL_LATCH, 32'h0);
        $display("reset values done");
    endtask
    task t_sticky;
        cwr(csi_pkg::CSI_SEL_STICKY, 32'hffff_ffff);
        crd(csi_pkg::CSI_SEL_STICKY, 32'h0006_03e7);
        cwr(csi_pkg::CSI_SEL_STICKY, 32'h0);
        cyc;
        arith_i.alu_fix = 1'b1;
        stack_i = '{pc_full: 1'b1, ss_ovf: 1'b1, default: 1'b0};
        cyc;
        arith_i.alu_fix = 1'b0;
        stack_i.ss_ovf = 1'b0;
        crd(csi_pkg::CSI_SEL_STICKY, 32'h00a0_0004);
        cyc;
        stack_i.pc_full = 1'b0;
        core_sel = csi_pkg::CSI_SEL_STICKY;
        core_wdata = 32'h0;
        core_wr = 1'b1;
        arith_i.alu_unf = 1'b1;
        cyc;
        core_wr = 1'b0;
        arith_i.alu_unf = 1'b0;
        crd(csi_pkg::CSI_SEL_STICKY, 32'h0080_0001);
        $display("sticky status done");
    endtask
    task t_irq;
        cwr(csi_pkg::CSI_SEL_LATCH, 32'h0);
        cwr(csi_pkg::CSI_SEL_MASK, 32'h0);
        crd(csi_pkg::CSI_SEL_MASK, 32'h0000_0002);
        cwr(csi_pkg::CSI_SEL_MASK, 32'h0000_0400);
        cyc;
        irqsrc_i.dma_done = 10'h201;
        cyc;
        irqsrc_i.dma_done = 10'h0;
        cmp({31'h0, irq_req_reg}, 32'h1);
        cmp(irq_vector_reg, 32'h0040_0028);
        cwr(csi_pkg::CSI_SEL_MASK, 32'hffff_ffff);
        crd(csi_pkg::CSI_SEL_MASK, 32'hffff_fdfa);
        irqsrc_i.tmr_zero = 1'b1;
        cyc;
        irqsrc_i.tmr_zero = 1'b0;
        cmp(irq_vector_reg, 32'h0040_0010);
        crd(csi_pkg::CSI_SEL_LATCH, 32'h0088_0410);
        cwr(csi_pkg::CSI_SEL_LATCH, 32'h0);
        cyc;
        cmp({31'h0, irq_req_reg}, 32'h0);
        $display("interrupts done");
    endtask
    task t_config;
        cwr(csi_pkg::CSI_SEL_CONFIG, 32'h0000_040e);
        cwr(csi_pkg::CSI_SEL_LATCH, 32'h1000_0000);
        cyc;
        cmp(irq_vector_reg, 32'h0002_0070);
        cmp({30'h0, ctrl_reg.mem_select_en, ctrl_reg.boot_mem_sel}, 32'h1);
        cmp({31'h0, ctrl_reg.ready_oe_n}, 32'h0);
        cmp({31'h0, ctrl_reg.direct_word48}, 32'h1);
        crd(csi_pkg::CSI_SEL_CONFIG, 32'h0000_040e);
        cwr(csi_pkg::CSI_SEL_CONFIG, 32'hffff_ff8e);
        crd(csi_pkg::CSI_SEL_CONFIG, 32'h1007_ff0e);
        cwr(csi_pkg::CSI_SEL_CONFIG, 32'h0000_0001);
        cmp({31'h0, soft_reset_reg}, 32'h1);
        cyc;
        cmp(cfg_reg, 32'h0000_0010);
        crd(csi_pkg::CSI_SEL_LATCH, 32'h0);
        $display("configuration and soft reset done");
    endtask
    task t_host;
        cyc;
        host_addr = 8'h00;
        host_wdata = 32'h0000_0030;
        host_wr = 1'b1;
        cyc;
        cmp(cfg_reg, 32'h0000_0010);
        host_wdata = 32'h0000_0000;
        cyc;
        cmp(cfg_reg, 32'h0000_0030);
        host_wdata = 32'h0000_0050;
        cyc;
        host_wr = 1'b0;
        cmp(cfg_reg, 32'h0000_0050);
        host_rd = 1'b1;
        cyc;
        cmp(host_rdata_reg, 32'h0000_0050);
        host_addr = 8'h04;
        cyc;
        host_rd = 1'b0;
        cmp(host_rdata_reg, 32'h0);
        $display("host port done");
    endtask
    initial begin
        #200000;
        n_mismatch++;
        end_sim;
    end
    initial begin
        repeat (16) @(posedge clk_sys);
        #10;
        reset_n = 1'b1;
        t_reset;
        t_sticky;
        t_irq;
        t_config;
        t_host;
        end_sim;
    end
endmodule
